// ### logic/pdio_defs.vh
// constants for the paged digital i/o block: offsets, fields, reset values
// assumes inclusion by bare name from the design file
`ifndef PDIO_DEFS_VH
`define PDIO_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PDIO_ADDR_W 4
`define PDIO_OFS_PORT0 4'h0
`define PDIO_OFS_PORT5 4'h5
`define PDIO_OFS_SUMMARY 4'h6
`define PDIO_OFS_PAGELOCK 4'h7
`define PDIO_OFS_PAGED0 4'h8
`define PDIO_OFS_PAGED2 4'ha

// ----------------------------------------
// page/lock fields
// ----------------------------------------
`define PDIO_PAGE_HI 7
`define PDIO_PAGE_LO 6
`define PDIO_LOCK_HI 5
`define PDIO_LOCK_LO 0
`define PDIO_PAGE_POL 2'h1
`define PDIO_PAGE_ENA 2'h2
`define PDIO_PAGE_FLAG 2'h3

// ----------------------------------------
// reset values
// ----------------------------------------
`define PDIO_RST_PORT 8'h00
`define PDIO_RST_PAGELOCK 8'h00
`define PDIO_RST_POL 8'h00
`define PDIO_RST_ENA 8'h00
`define PDIO_RST_FLAG 8'h00

`endif

// ### logic/pdio_top.v
// paged 48-line open-drain digital i/o with per-bit edge flags on ports 0-2 only
// assumes host strobes and clk_sys share one clock, pins are synchronised in; pads resolve the open drain
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ns
`include "pdio_defs.vh"

// Functional notes
// - each bit is independently input or output
// - writing 0 releases the pin driver
// - port reads return the inverted pin level
// - writing 1 drives the pin low
// - summary is read-only, derived from flags
// - summary bit set when port has flags
// - page/lock top two bits select page
// - lock bits 5-0 block port writes
// - polarity registers visible on page 1
// - polarity 1 selects rising edges
// - polarity 0 selects falling edges
// - enable registers visible on page 2
// - enable 1 allows detection and flagging
// - enable 0 disables edge detection
// - disable then enable clears one flag
// - flag registers visible on page 3
// - flag reads 1 after qualifying edge
// - any flag register write clears all bits of that register
// - forty-eight lines as six byte ports
module pdio_top #(
    parameter NPORTS = 6,
    parameter NIRQ = 3
) (
    // clock and reset
    input wire clk_sys,
    input wire nrst,
    // register port
    input wire [`PDIO_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // open-drain pins
    input wire [NPORTS*8-1:0] pin_in,
    output wire [NPORTS*8-1:0] pin_out,
    output wire [NPORTS*8-1:0] pin_oe,
    // interrupt request
    output wire irq
);

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    reg rst_meta;
    reg rst_sync;
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end
    wire rst_n = rst_sync;

    // ----------------------------------------
    // register storage
    // ----------------------------------------
    // each byte is owned by one generate entry, so the wide views are plain nets
    wire [NPORTS*8-1:0] port_drive;
    reg [7:0] page_lock;
    wire [NIRQ*8-1:0] edge_polarity_regs;
    wire [NIRQ*8-1:0] edge_enable_regs;
    wire [NIRQ*8-1:0] edge_flag_regs;
    wire [1:0] page = page_lock[`PDIO_PAGE_HI:`PDIO_PAGE_LO];
    wire paged_hit = (reg_addr >= `PDIO_OFS_PAGED0) && (reg_addr <= `PDIO_OFS_PAGED2);
    wire [1:0] paged_idx = reg_addr[1:0];

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // two stages then a history stage; edges come only from the second and third
    reg [NPORTS*8-1:0] pin_meta;
    reg [NPORTS*8-1:0] pin_sync;
    reg [NPORTS*8-1:0] pin_prev;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= {NPORTS*8{1'b1}};
            pin_sync <= {NPORTS*8{1'b1}};
            pin_prev <= {NPORTS*8{1'b1}};
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // ----------------------------------------
    // open-drain drive
    // ----------------------------------------
    // a one sinks the line, a zero floats it to the external pull-up
    assign pin_out = {NPORTS*8{1'b0}};
    assign pin_oe = port_drive;

    // ----------------------------------------
    // port and page/lock writes
    // ----------------------------------------
    genvar p;
    generate
        for (p = 0; p < NPORTS; p = p + 1) begin : g_port
            localparam [`PDIO_ADDR_W-1:0] OFS = p;
            reg [7:0] drive;
            wire hit = reg_wr && (reg_addr == OFS);
            always @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    drive <= `PDIO_RST_PORT;
                end else if (hit && !page_lock[`PDIO_LOCK_LO+p]) begin
                    drive <= reg_wdata;
                end
            end
            assign port_drive[p*8+7:p*8] = drive;
        end
    endgenerate

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            page_lock <= `PDIO_RST_PAGELOCK;
        end else if (reg_wr && reg_addr == `PDIO_OFS_PAGELOCK) begin
            page_lock <= reg_wdata;
        end
    end

    // ----------------------------------------
    // paged registers and edge flags
    // ----------------------------------------
    genvar q;
    generate
        for (q = 0; q < NIRQ; q = q + 1) begin : g_irq
            localparam [1:0] IDX = q;
            reg [7:0] pol;
            reg [7:0] ena;
            reg [7:0] flag;
            wire sel = reg_wr && paged_hit && (paged_idx == IDX);
            wire pol_wr = sel && (page == `PDIO_PAGE_POL);
            wire ena_wr = sel && (page == `PDIO_PAGE_ENA);
            wire flag_wr = sel && (page == `PDIO_PAGE_FLAG);
            wire [7:0] now = pin_sync[q*8+7:q*8];
            wire [7:0] was = pin_prev[q*8+7:q*8];
            // rising where polarity is 1, falling where it is 0
            wire [7:0] hit_edge = ((now & ~was & pol) | (~now & was & ~pol))
                & ena;
            // a disabled bit loses its flag, so re-enabling leaves it clear
            wire [7:0] keep = flag_wr ? 8'h00 : ena;
            always @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    pol <= `PDIO_RST_POL;
                    ena <= `PDIO_RST_ENA;
                    flag <= `PDIO_RST_FLAG;
                end else begin
                    if (pol_wr) begin
                        pol <= reg_wdata;
                    end
                    if (ena_wr) begin
                        ena <= reg_wdata;
                    end
                    // a new edge wins over a clear in the same cycle
                    flag <= (flag & keep) | hit_edge;
                end
            end
            assign edge_polarity_regs[q*8+7:q*8] = pol;
            assign edge_enable_regs[q*8+7:q*8] = ena;
            assign edge_flag_regs[q*8+7:q*8] = flag;
        end
    endgenerate

    // ----------------------------------------
    // summary and interrupt
    // ----------------------------------------
    wire [7:0] summary;
    genvar s;
    generate
        for (s = 0; s < 8; s = s + 1) begin : g_sum
            if (s < NIRQ) begin : g_on
                assign summary[s] = |edge_flag_regs[s*8+7:s*8];
            end else begin : g_off
                assign summary[s] = 1'b0;
            end
        end
    endgenerate
    assign irq = |summary;

    // ----------------------------------------
    // read data
    // ----------------------------------------
    reg [7:0] next_rdata;
    always @* begin
        next_rdata = 8'h00;
        if (reg_addr <= `PDIO_OFS_PORT5) begin
            next_rdata = ~pin_sync[reg_addr[2:0]*8 +: 8];
        end else if (reg_addr == `PDIO_OFS_SUMMARY) begin
            next_rdata = summary;
        end else if (reg_addr == `PDIO_OFS_PAGELOCK) begin
            next_rdata = page_lock;
        end else if (paged_hit && paged_idx < NIRQ) begin
            case (page)
                `PDIO_PAGE_POL: next_rdata = edge_polarity_regs[paged_idx*8 +: 8];
                `PDIO_PAGE_ENA: next_rdata = edge_enable_regs[paged_idx*8 +: 8];
                `PDIO_PAGE_FLAG: next_rdata = edge_flag_regs[paged_idx*8 +: 8];
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

// ### test/pdio_top_asserts.sv
// checker for the paged i/o block, watching only its top ports
// assumes one clock domain and a bind from this file
`timescale 1ns/1ns
module pdio_top_asserts #(
    parameter NPORTS = 6,
    parameter NIRQ = 3
) (
    // clock and reset
    input wire clk_sys,
    input wire nrst,
    // register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    // pins and interrupt
    input wire [NPORTS*8-1:0] pin_in,
    input wire [NPORTS*8-1:0] pin_out,
    input wire [NPORTS*8-1:0] pin_oe,
    input wire irq
);
    // --------------
    // shadow of page/lock
    // --------------
    reg [7:0] pl;
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pl <= 8'h00;
        end else if (reg_wr && reg_addr == 4'h7) begin
            pl <= reg_wdata;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // --------------
    // properties
    // --------------
    property p_od_out; pin_out == 48'h0; endproperty
    a_od_out: assert property (p_od_out) else $error("pin_out not zero");
    property p_port_rd;
        reg_rd && reg_addr == 4'h0 && $past(pin_in[7:0]) == pin_in[7:0]
        && $past(pin_in[7:0], 2) == pin_in[7:0]
        |=> reg_rdata == ~$past(pin_in[7:0]);
    endproperty
    a_port_rd: assert property (p_port_rd) else $error("port read not inverted");
    property p_port_wr;
        reg_wr && reg_addr < 4'h6 && !pl[reg_addr] |=>
        pin_oe[8*$past(reg_addr) +: 8] == $past(reg_wdata);
    endproperty
    a_port_wr: assert property (p_port_wr) else $error("port write lost");
    property p_lock; reg_wr && reg_addr < 4'h6 && pl[reg_addr] |=> $stable(pin_oe); endproperty
    a_lock: assert property (p_lock) else $error("locked port changed");
    property p_oe_hold; $changed(pin_oe) |-> $past(reg_wr && reg_addr < 4'h6); endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("drive changed unasked");
    property p_irq;
        reg_rd && reg_addr == 4'h6 |=>
        (reg_rdata[2:0] != 3'h0) == $past(irq) && reg_rdata[7:3] == 5'h00;
    endproperty
    a_irq: assert property (p_irq) else $error("irq and summary differ");
    property p_unmapped;
        reg_rd && (reg_addr > 4'ha || (reg_addr > 4'h7 && pl[7:6] == 2'h0)) |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
    property p_page_rd; reg_rd && reg_addr == 4'h7 |=> reg_rdata == $past(pl); endproperty
    a_page_rd: assert property (p_page_rd) else $error("page/lock readback wrong");
endmodule
bind pdio_top pdio_top_asserts #(.NPORTS(NPORTS), .NIRQ(NIRQ)) u_chk (.clk_sys(clk_sys),
    .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));

// ### test/pdio_pins.sv
// open-drain line model: pull-ups plus optional outside sinks
// assumes the block only sinks, so any sink pulls a line low
`timescale 1ns/1ns
module pdio_pins (
    // block side
    input wire [47:0] pin_oe,
    output wire [47:0] pin_in,
    // outside sinks from the bench
    input wire [47:0] ext_low
);
    assign pin_in = ~(pin_oe | ext_low);
endmodule

// ### test/pdio_top_tb.sv
// bench for the paged i/o block: register tasks and self checks
// assumes pdio_pins as line model and the bound checker
`timescale 1ns/1ns
module pdio_top_tb;
    // --------------
    // stimulus and wires
    // --------------
    reg clk_sys = 1'b0;
    reg nrst = 1'b0;
    reg [3:0] reg_addr = 4'h0;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [47:0] ext_low = 48'h0;
    wire [7:0] reg_rdata;
    wire [47:0] pin_in;
    wire [47:0] pin_out;
    wire [47:0] pin_oe;
    wire irq;
    integer n_errors = 0;
    integer checked = 0;
    integer cyc = 0;
    integer p;
    always #25 clk_sys = ~clk_sys;
    pdio_top DUT (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
    pdio_pins u_pins (.pin_oe(pin_oe), .pin_in(pin_in), .ext_low(ext_low));
    task test_done;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task chk(input [7:0] act, input [7:0] exp);
        checked = checked + 1;
        if (act !== exp) begin
            $display("MISMATCH %0t act %h exp %h", $time, act, exp);
            n_errors = n_errors + 1;
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask
    task rd(input [3:0] a, input [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask
    // hang guard, far above the under two hundred cycles the run needs
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            n_errors = n_errors + 1;
            test_done;
        end
    end
    // --------------
    // tests
    // --------------
    initial begin
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(4'h7, 8'h00);
        rd(4'h6, 8'h00);
        for (p = 0; p < 6; p = p + 1) begin
            wr(p[3:0], 8'ha5 ^ p[7:0]);
            chk(pin_oe[8*p +: 8], 8'ha5 ^ p[7:0]);
            repeat (2) @(posedge clk_sys);
            rd(p[3:0], 8'ha5 ^ p[7:0]);
            wr(p[3:0], 8'h00);
            chk(pin_oe[8*p +: 8], 8'h00);
            @(posedge clk_sys);
            ext_low[8*p +: 8] <= 8'h3c;
            repeat (3) @(posedge clk_sys);
            rd(p[3:0], 8'h3c);
            ext_low <= 48'h0;
        end
        wr(4'h7, 8'h21);
        wr(4'h0, 8'hff);
        wr(4'h1, 8'hff);
        chk(pin_oe[7:0], 8'h00);
        chk(pin_oe[15:8], 8'hff);
        rd(4'h7, 8'h21);
        wr(4'h1, 8'h00);
        wr(4'h7, 8'h40);
        wr(4'h8, 8'h02);
        rd(4'h8, 8'h02);
        wr(4'h7, 8'h80);
        rd(4'h8, 8'h00);
        wr(4'h8, 8'h03);
        wr(4'h7, 8'h00);
        rd(4'h8, 8'h00);
        rd(4'hb, 8'h00);
        wr(4'h7, 8'hc0);
        @(posedge clk_sys);
        ext_low[7:0] <= 8'h83;
        repeat (4) @(posedge clk_sys);
        rd(4'h8, 8'h01);
        rd(4'h6, 8'h01);
        chk({7'h00, irq}, 8'h01);
        @(posedge clk_sys);
        ext_low <= 48'h0;
        repeat (4) @(posedge clk_sys);
        rd(4'h8, 8'h03);
        wr(4'h7, 8'h80);
        wr(4'h8, 8'h02);
        wr(4'h8, 8'h03);
        wr(4'h7, 8'hc0);
        rd(4'h8, 8'h02);
        wr(4'h6, 8'hff);
        rd(4'h6, 8'h01);
        wr(4'h8, 8'h5a);
        rd(4'h8, 8'h00);
        rd(4'h6, 8'h00);
        chk({7'h00, irq}, 8'h00);
        test_done;
    end
endmodule
